// ### bench/dac_output_and_lvds_status_regs_test.sv
`timescale 1ns/10ps
module dac_output_and_lvds_status_regs_test;
    typedef struct packed {
        logic [7:0] addr;  // register written
        logic [7:0] data;  // byte written
        logic [9:0] code;  // expected code afterwards
        logic       sleep; // expected sleep afterwards
        logic [1:0] mode;  // expected decoder mode
        logic [1:0] bias;  // expected bias code
    } row_t;
    logic        ref_clk = 1'b0;   // 50 MHz
    logic        resetn  = 1'b0;   // active low
    logic [3:0]  rise    = 4'h0;   // rising handoff events
    logic [3:0]  fall    = 4'h0;   // falling handoff events
    logic [14:0] st      = 15'h0000; // other status levels
    logic [7:0]  addr, wdata, rdata, q;
    logic        wr, rd, rvalid, sleep, en, clr;
    logic [9:0]  code;
    logic [1:0]  bias;
    dac_regs_pkg::decoder_mode_t mode;
    int          mismatches = 0;
    int          checks     = 0;
    row_t        rows [12]  = '{
        '{8'h06, 8'hFF, 10'h2FF, 1'b0, 2'h0, 2'h0},
        '{8'h07, 8'h83, 10'h3FF, 1'b1, 2'h0, 2'h0},
        '{8'h07, 8'h02, 10'h2FF, 1'b0, 2'h0, 2'h0},
        '{8'h06, 8'h00, 10'h200, 1'b0, 2'h0, 2'h0},
        '{8'h07, 8'h00, 10'h000, 1'b0, 2'h0, 2'h0},
        '{8'h08, 8'h01, 10'h000, 1'b0, 2'h1, 2'h0},
        '{8'h08, 8'h02, 10'h000, 1'b0, 2'h2, 2'h0},
        '{8'h08, 8'h03, 10'h000, 1'b0, 2'h3, 2'h0},
        '{8'h08, 8'h00, 10'h000, 1'b0, 2'h0, 2'h0},
        '{8'h0A, 8'h01, 10'h000, 1'b0, 2'h0, 2'h1},
        '{8'h0A, 8'h02, 10'h000, 1'b0, 2'h0, 2'h2},
        '{8'h0A, 8'h03, 10'h000, 1'b0, 2'h0, 2'h3}
    };
    // free-running register clock
    always #10 ref_clk = ~ref_clk;
    host_model host_model_i (.ref_clk_i(ref_clk), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
        .reg_addr_o(addr), .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));
    dac_output_status_regs dac_output_status_regs_i (
        .ref_clk_i(ref_clk), .resetn_i(resetn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .full_scale_code_o(code), .output_sleep_o(sleep), .output_current_enable_o(en),
        .decoder_mode_o(mode), .link_bias_o(bias), .handoff_check_clear_o(clr),
        .rise_handoff_event_i(rise), .fall_handoff_event_i(fall),
        .clock_late_phase_zero_i(st[8]), .clock_late_phase_two_i(st[9]),
        .clock_early_phase_zero_i(st[10]), .clock_early_phase_two_i(st[11]),
        .divider_phase_one_status_i(st[12]), .divider_phase_three_status_i(st[13]),
        .second_phase_delay_sample_i(st[14]), .port0_under_range_i(st[0]),
        .port0_over_range_i(st[1]), .port1_under_range_i(st[2]), .port1_over_range_i(st[3]),
        .sync_phase_zero_sample_i(st[4]), .sync_phase_one_sample_i(st[5]),
        .first_phase_delay_sample_i(st[6]), .sync_delay_sample_i(st[7]));
    // one comparison, counted, reported at once on a miss
    task automatic chk(input string name, input logic [9:0] exp, input logic [9:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // read a register and compare the byte
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        host_model_i.rd(a, q);
        chk("readback", {2'b00, exp}, {2'b00, q});
    endtask
    // the single place where the run ends
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // hang guard: the whole sequence needs well under 1000 cycles
    initial begin
        #100000;
        mismatches++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge ref_clk);
        #1;
        chk("code", 10'h200, code);
        chk("sleep", 10'h000, {9'h000, sleep});
        chk("enable", 10'h001, {9'h000, en});
        chk("mode", 10'h000, {8'h00, mode});
        chk("bias", 10'h000, {8'h00, bias});
        chk("clear", 10'h000, {9'h000, clr});
        chk("rvalid", 10'h000, {9'h000, rvalid});
        chk("rdata", 10'h000, {2'b00, rdata});
        @(posedge ref_clk);
        resetn <= 1'b1;
        for (int a = 11; a <= 13; a++) rchk(8'(a), 8'h00);
        // ordinary writes: code, sleep, enable, mode and bias checked after each
        foreach (rows[i]) begin
            host_model_i.wr(rows[i].addr, rows[i].data);
            repeat (2) @(posedge ref_clk);
            #1;
            chk("code", rows[i].code, code);
            chk("sleep", {9'h000, rows[i].sleep}, {9'h000, sleep});
            chk("enable", {9'h000, ~rows[i].sleep}, {9'h000, en});
            chk("mode", {8'h00, rows[i].mode}, {8'h00, mode});
            chk("bias", {8'h00, rows[i].bias}, {8'h00, bias});
        end
        host_model_i.wr(8'h06, 8'h5A);
        rchk(8'h06, 8'h5A);
        rchk(8'h09, 8'h00);
        // sticky handoff flags, ignored status write, clear with a live event
        @(posedge ref_clk);
        rise <= 4'h5;
        fall <= 4'hA;
        repeat (5) @(posedge ref_clk);
        rise <= 4'h2;
        fall <= 4'h0;
        repeat (6) @(posedge ref_clk);
        rchk(8'h0B, 8'hA7);
        host_model_i.wr(8'h0B, 8'h00);
        rchk(8'h0B, 8'hA7);
        host_model_i.clear_flags(2'h3);
        rchk(8'h0B, 8'h02);
        @(posedge ref_clk);
        rise <= 4'h0;
        repeat (6) @(posedge ref_clk);
        host_model_i.clear_flags(2'h3);
        rchk(8'h0B, 8'h00);
        chk("clear", 10'h000, {9'h000, clr});
        chk("bias", 10'h003, {8'h00, bias});
        // level status: two complementary patterns through both registers
        for (int p = 0; p < 2; p++) begin
            @(posedge ref_clk);
            st <= (p == 0) ? 15'h2AAA : 15'h5555;
            repeat (6) @(posedge ref_clk);
            rchk(8'h0C, {st[14], 1'b0, st[13:8]});
            rchk(8'h0D, st[7:0]);
        end
        // mid-run reset with the clear bit set: every control but the enable checked back at reset
        host_model_i.wr(8'h0A, 8'h0B);
        #1;
        chk("clear", 10'h001, {9'h000, clr});
        @(posedge ref_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk("code", 10'h200, code);
        chk("sleep", 10'h000, {9'h000, sleep});
        chk("mode", 10'h000, {8'h00, mode});
        chk("bias", 10'h000, {8'h00, bias});
        chk("clear", 10'h000, {9'h000, clr});
        chk("rdata", 10'h000, {2'b00, rdata});
        @(posedge ref_clk);
        resetn <= 1'b1;
        rchk(8'h0B, 8'h00);
        rchk(8'h07, 8'h02);
        end_of_test();
    end
endmodule

// ### bench/host_model.sv
`timescale 1ns/10ps
// register host: one strobe per access, same clock as the block
module host_model (
    input  wire logic       ref_clk_i,
    input  wire logic [7:0] reg_rdata_i,
    input  wire logic       reg_rvalid_i,
    output logic      [7:0] reg_addr_o,
    output logic      [7:0] reg_wdata_o,
    output logic            reg_wr_o,
    output logic            reg_rd_o
);
    // idle port at time zero
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
        reg_rd_o    = 1'b0;
    end
    // write: strobe for one edge, then scramble data so stale bytes never pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_addr_o  <= a;
        reg_wdata_o <= d;
        reg_wr_o    <= 1'b1;
        @(posedge ref_clk_i);
        reg_wr_o    <= 1'b0;
        reg_wdata_o <= ~d;
    endtask
    // read: strobe one edge, wait for the answer under a bounded count
    task automatic rd(input logic [7:0] a, output logic [7:0] q);
        q = 8'hXX;
        @(posedge ref_clk_i);
        reg_addr_o <= a;
        reg_rd_o   <= 1'b1;
        @(posedge ref_clk_i);
        reg_rd_o   <= 1'b0;
        repeat (4) begin
            #1;
            if (reg_rvalid_i === 1'b1) begin
                q = reg_rdata_i;
                break;
            end
            @(posedge ref_clk_i);
        end
    endtask
    // clear pulse: high then low again, keeping the bias code
    task automatic clear_flags(input logic [1:0] bias);
        wr(8'h0A, {4'h0, 1'b1, 1'b0, bias});
        wr(8'h0A, {6'h00, bias});
    endtask
endmodule

// ### verilog/dac_output_status_regs.sv
`timescale 1ns/10ps
`include "dac_regs_map.svh"

// What this block does
// - code split over 0x06, 0x07; sleep bit7
// - code maps 10/20/30 mA; resets 0x200
// - sleep forces output current to zero
// - decoder mode field selects four modes
// - clear bit wipes all handoff flags except those with a live event
// - bias field selects receiver bias current
// - falling-edge handoff flags report violations
// - rising-edge handoff flags report violations
// - phase three bit high when misaligned
// - phase one bit high when aligned
// - early bits flag clock before edge
// - late bits flag clock after edge
// - divider phase delay samples, reset zero
// - sync delay sample readable
// - sync samples by phases one, zero
// - per-port over and under range flags
module dac_output_status_regs (
    input  wire logic                   ref_clk_i,
    input  wire logic                   resetn_i,
    // register port from the serial host logic, same clock
    input  wire logic [7:0]             reg_addr_i,
    input  wire logic [7:0]             reg_wdata_i,
    input  wire logic                   reg_wr_i,
    input  wire logic                   reg_rd_i,
    output logic      [7:0]             reg_rdata_o,
    output logic                        reg_rvalid_o,
    // controls toward the analog core
    output logic      [9:0]             full_scale_code_o,
    output logic                        output_sleep_o,
    output logic                        output_current_enable_o,
    output dac_regs_pkg::decoder_mode_t decoder_mode_o,
    output logic      [1:0]             link_bias_o,
    output logic                        handoff_check_clear_o,
    // raw status from the analog side, asynchronous
    input  wire logic [3:0]             rise_handoff_event_i,
    input  wire logic [3:0]             fall_handoff_event_i,
    input  wire logic                   clock_late_phase_zero_i,
    input  wire logic                   clock_late_phase_two_i,
    input  wire logic                   clock_early_phase_zero_i,
    input  wire logic                   clock_early_phase_two_i,
    input  wire logic                   divider_phase_one_status_i,
    input  wire logic                   divider_phase_three_status_i,
    input  wire logic                   second_phase_delay_sample_i,
    input  wire logic                   port0_under_range_i,
    input  wire logic                   port0_over_range_i,
    input  wire logic                   port1_under_range_i,
    input  wire logic                   port1_over_range_i,
    input  wire logic                   sync_phase_zero_sample_i,
    input  wire logic                   sync_phase_one_sample_i,
    input  wire logic                   first_phase_delay_sample_i,
    input  wire logic                   sync_delay_sample_i
);

    // raw status, packed in register bit order per group
    // one flat vector keeps the synchroniser a single generate loop
    wire logic [`STAT_W-1:0] stat_raw;
    assign stat_raw = {sync_delay_sample_i, first_phase_delay_sample_i,
                       sync_phase_one_sample_i, sync_phase_zero_sample_i,
                       port1_over_range_i, port1_under_range_i,
                       port0_over_range_i, port0_under_range_i,
                       second_phase_delay_sample_i, divider_phase_three_status_i,
                       divider_phase_one_status_i, clock_early_phase_two_i,
                       clock_early_phase_zero_i, clock_late_phase_two_i,
                       clock_late_phase_zero_i,
                       fall_handoff_event_i, rise_handoff_event_i};

    logic [`STAT_W-1:0] sync_a;          // first stage, read only by sync_b
    logic [`STAT_W-1:0] sync_b;          // second stage
    logic [`STAT_W-1:0] sync_c;          // third stage
    logic [`STAT_W-1:0] stat_filt;       // accepted status value

    // three-stage synchroniser; a change counts once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < `STAT_W; gi = gi + 1) begin : g_sync
            always_ff @(posedge ref_clk_i) begin
                if (!resetn_i) begin
                    sync_a[gi]    <= 1'b0;
                    sync_b[gi]    <= 1'b0;
                    sync_c[gi]    <= 1'b0;
                    stat_filt[gi] <= 1'b0;   // samples read zero after reset
                end else begin
                    sync_a[gi] <= stat_raw[gi];
                    sync_b[gi] <= sync_a[gi];
                    sync_c[gi] <= sync_b[gi];
                    // holding on disagreement rejects a single metastable glitch
                    if (sync_b[gi] == sync_c[gi]) begin
                        stat_filt[gi] <= sync_c[gi];
                    end
                end
            end
        end
    endgenerate

    // address decode
    // full 8-bit compare, so aliases of mapped registers read zero
    wire logic hit_fsc_low;
    wire logic hit_fsc_high;
    wire logic hit_decoder;
    wire logic hit_bias;
    wire logic hit_handoff;
    wire logic hit_phase;
    wire logic hit_sync;
    assign hit_fsc_low  = (reg_addr_i == `ADDR_FSC_LOW);
    assign hit_fsc_high = (reg_addr_i == `ADDR_FSC_HIGH);
    assign hit_decoder  = (reg_addr_i == `ADDR_DECODER);
    assign hit_bias     = (reg_addr_i == `ADDR_LINK_BIAS);
    assign hit_handoff  = (reg_addr_i == `ADDR_HANDOFF);
    assign hit_phase    = (reg_addr_i == `ADDR_PHASE_STAT);
    assign hit_sync     = (reg_addr_i == `ADDR_SYNC_STAT);

    // sticky handoff flags, rise in low nibble, fall in high nibble
    logic [7:0] handoff_flags;
    wire logic [7:0] handoff_events;
    wire logic [7:0] next_handoff_flags;
    assign handoff_events = stat_filt[`FALL_MSB:`RISE_LSB];
    // a live violation wins over the clear, so no event is lost
    assign next_handoff_flags = (handoff_check_clear_o ? 8'h00 : handoff_flags)
                                | handoff_events;

    // read data selection; unmapped addresses read zero
    wire logic [7:0] read_mux;
    assign read_mux =
        hit_fsc_low  ? full_scale_code_o[`FSC_LOW_MSB:0] :
        hit_fsc_high ? {output_sleep_o, 5'h00,
                        full_scale_code_o[`FSC_MSB:`FSC_HIGH_LSB]} :
        hit_decoder  ? {6'h00, decoder_mode_o} :
        hit_bias     ? {4'h0, handoff_check_clear_o, 1'b0, link_bias_o} :
        hit_handoff  ? handoff_flags :
        hit_phase    ? {stat_filt[`PHASE_MSB], 1'b0,
                        stat_filt[`PHASE_MSB-1:`PHASE_LSB]} :
        hit_sync     ? stat_filt[`SYNC_MSB:`SYNC_LSB] :
                       8'h00;

    // control registers; writes to status addresses fall through untouched
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            full_scale_code_o     <= `FSC_RESET;
            output_sleep_o        <= `SLEEP_RESET;
            decoder_mode_o        <= dac_regs_pkg::DEC_NORMAL;
            link_bias_o           <= `BIAS_RESET;
            handoff_check_clear_o <= `CLEAR_RESET;
        end else if (reg_wr_i) begin
            if (hit_fsc_low) begin
                full_scale_code_o[`FSC_LOW_MSB:0] <= reg_wdata_i;
            end else if (hit_fsc_high) begin
                full_scale_code_o[`FSC_MSB:`FSC_HIGH_LSB] <= reg_wdata_i[`FSC_HIGH_MSB:0];
                output_sleep_o <= reg_wdata_i[`SLEEP_BIT];
            end else if (hit_decoder) begin
                decoder_mode_o <= dac_regs_pkg::decoder_mode_t'(reg_wdata_i[`DEC_MSB:0]);
            end else if (hit_bias) begin
                link_bias_o           <= reg_wdata_i[`BIAS_MSB:0];
                handoff_check_clear_o <= reg_wdata_i[`CLEAR_BIT];
            end
        end
    end

    // output current gate follows the sleep bit one cycle later
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            output_current_enable_o <= 1'b1;
        end else begin
            output_current_enable_o <= !output_sleep_o;
        end
    end

    // handoff flag storage
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            handoff_flags <= 8'h00;
        end else begin
            handoff_flags <= next_handoff_flags;
        end
    end

    // read answer, one cycle after the strobe
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            reg_rdata_o  <= 8'h00;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= read_mux;
            end
        end
    end

    // low byte of the code follows a write to its address
    fsc_low_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && hit_fsc_low |=>
        full_scale_code_o[`FSC_LOW_MSB:0] == $past(reg_wdata_i))
        else $error("full-scale low byte not written");

    // fresh reset puts the code at mid scale
    fsc_reset_a: assert property (@(posedge ref_clk_i)
        $rose(resetn_i) |-> full_scale_code_o == `FSC_RESET && !output_sleep_o)
        else $error("full-scale reset value wrong");

    // sleep removes output current within two cycles of the write
    sleep_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && hit_fsc_high && reg_wdata_i[`SLEEP_BIT] |=> ##1
        !output_current_enable_o)
        else $error("sleep did not gate output current");

    // decoder mode takes the written code
    decoder_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && hit_decoder |=> decoder_mode_o == $past(reg_wdata_i[`DEC_MSB:0]))
        else $error("decoder mode not written");

    // bias field takes the written code
    bias_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && hit_bias |=> link_bias_o == $past(reg_wdata_i[`BIAS_MSB:0]))
        else $error("bias field not written");

    // clear with no live event empties the flags next cycle
    handoff_clear_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        handoff_check_clear_o && handoff_events == 8'h00 |=> handoff_flags == 8'h00)
        else $error("handoff flags not cleared");

    // set flags stay set while the clear is low, writes or not
    handoff_sticky_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        !handoff_check_clear_o |=> (handoff_flags & $past(handoff_flags))
                                   == $past(handoff_flags))
        else $error("handoff flag dropped without clear");

    // status read returns the accepted sync and range bits
    sync_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_sync |=> reg_rvalid_o
                                 && reg_rdata_o == $past(stat_filt[`SYNC_MSB:`SYNC_LSB]))
        else $error("sync status read wrong");

    // high byte write moves code bits 9:8 and the sleep bit
    fsc_high_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && hit_fsc_high |=>
        full_scale_code_o[`FSC_MSB:`FSC_HIGH_LSB] == $past(reg_wdata_i[`FSC_HIGH_MSB:0])
        && output_sleep_o == $past(reg_wdata_i[`SLEEP_BIT]))
        else $error("full-scale high byte not written");

    // waking restores output current two cycles after the write
    wake_gate_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && hit_fsc_high && !reg_wdata_i[`SLEEP_BIT] |=> ##1
        output_current_enable_o)
        else $error("output current not restored");

    // the gate always mirrors the previous sleep value
    enable_follow_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        1'b1 |=> output_current_enable_o == !$past(output_sleep_o))
        else $error("output gate out of step with sleep");

    // clear bit takes the written value
    clear_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && hit_bias |=> handoff_check_clear_o == $past(reg_wdata_i[`CLEAR_BIT]))
        else $error("clear bit not written");

    // an accepted violation shows in the flags next cycle, clear or not
    handoff_set_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        1'b1 |=> (handoff_flags & $past(handoff_events)) == $past(handoff_events))
        else $error("handoff violation not flagged");

    // writes to status or unmapped addresses leave every control alone
    status_write_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_wr_i && !hit_fsc_low && !hit_fsc_high && !hit_decoder && !hit_bias |=>
        $stable(full_scale_code_o) && $stable(output_sleep_o) && $stable(decoder_mode_o)
        && $stable(link_bias_o) && $stable(handoff_check_clear_o))
        else $error("write to read-only address changed a control");

    // filter takes stage three on agreement and holds otherwise
    filter_accept_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        1'b1 |=> stat_filt == (($past(stat_filt) & $past(sync_b ^ sync_c))
                               | ($past(sync_c) & ~$past(sync_b ^ sync_c))))
        else $error("status filter took a wrong value");

    // phase status read returns the accepted clock bits
    phase_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_phase |=> reg_rvalid_o
        && reg_rdata_o == $past({stat_filt[`PHASE_MSB], 1'b0,
                                 stat_filt[`PHASE_MSB-1:`PHASE_LSB]}))
        else $error("phase status read wrong");

    // early and late bits sit in the low nibble of the phase read
    edge_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_phase |=>
        reg_rdata_o[3:0] == $past(stat_filt[`PHASE_LSB+3:`PHASE_LSB]))
        else $error("early or late bits read wrong");

    // handoff read returns the sticky flags
    handoff_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_handoff |=> reg_rvalid_o && reg_rdata_o == $past(handoff_flags))
        else $error("handoff flags read wrong");

    // high code byte reads back with sleep on top
    fsc_high_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_fsc_high |=> reg_rdata_o == $past({output_sleep_o, 5'h00,
                                     full_scale_code_o[`FSC_MSB:`FSC_HIGH_LSB]}))
        else $error("full-scale high byte read wrong");

    // decoder mode reads back in the low two bits
    decoder_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_decoder |=> reg_rdata_o == $past({6'h00, decoder_mode_o}))
        else $error("decoder mode read wrong");

    // bias and clear read back in place
    bias_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_bias |=> reg_rdata_o == $past({4'h0, handoff_check_clear_o,
                                                       1'b0, link_bias_o}))
        else $error("bias register read wrong");

    // sync delay sample lands in the top bit of its register
    sync_sample_read_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
        reg_rd_i && hit_sync |=> reg_rdata_o[7] == $past(stat_filt[`SYNC_MSB]))
        else $error("sync delay sample read wrong");

endmodule

// ### verilog/dac_regs_map.svh
`ifndef DAC_REGS_MAP_SVH
`define DAC_REGS_MAP_SVH

// register addresses on the host register port
`define ADDR_FSC_LOW      8'h06
`define ADDR_FSC_HIGH     8'h07
`define ADDR_DECODER      8'h08
`define ADDR_LINK_BIAS    8'h0A
`define ADDR_HANDOFF      8'h0B
`define ADDR_PHASE_STAT   8'h0C
`define ADDR_SYNC_STAT    8'h0D

// reset values
`define FSC_RESET         10'h200
`define SLEEP_RESET       1'b0
`define BIAS_RESET        2'h0
`define CLEAR_RESET       1'b0

// field positions inside the 8-bit registers
`define SLEEP_BIT         7
`define FSC_HIGH_MSB      1
`define DEC_MSB           1
`define CLEAR_BIT         3
`define BIAS_MSB          1
`define FSC_LOW_MSB       7
`define FSC_MSB           9
`define FSC_HIGH_LSB      8

// layout of the raw status vector coming from the analog side
`define STAT_W            23
`define RISE_LSB          0
`define RISE_MSB          3
`define FALL_LSB          4
`define FALL_MSB          7
`define PHASE_LSB         8
`define PHASE_MSB         14
`define SYNC_LSB          15
`define SYNC_MSB          22

`endif

// ### verilog/dac_regs_pkg.sv
package dac_regs_pkg;
    // output decoder modes, in register code order
    typedef enum logic [1:0] {
        DEC_NORMAL,
        DEC_RETURN_TO_ZERO,
        DEC_MIX,
        DEC_FLIP
    } decoder_mode_t;
endpackage
